// ===== uix_pkg.sv
// package: constants and types for the user instruction extension unit
package uix_pkg;
   localparam int XLEN = 32;
   // operation codes presented by the decoder
   typedef enum logic [4:0] {
      UIX_NOP, UIX_EXEC_BARRIER, UIX_REG_JUMP_HB, UIX_LINK_JUMP_HB, UIX_ERET,
      UIX_EXTRACT, UIX_INSERT, UIX_ROT_IMM, UIX_ROT_REG, UIX_SIGN_BYTE,
      UIX_SIGN_HALF, UIX_SWAP_HALF_BYTES, UIX_MOVE_FROM_FPU_UPPER,
      UIX_MOVE_TO_FPU_UPPER, UIX_MOVE_FROM_COP2_UPPER, UIX_MOVE_TO_COP2_UPPER,
      UIX_CACHE_SYNC, UIX_HWREG_READ, UIX_FPU_LOAD64, UIX_FPU_STORE64
   } uix_op_t;
   // hardware register numbers
   localparam logic [4:0] HWREG_PROC_NUM = 5'h0_0;
   localparam logic [4:0] HWREG_SYNC_STEP = 5'h0_1;
   localparam logic [4:0] HWREG_CYCLE_VIEW = 5'h0_2;
   localparam logic [4:0] HWREG_CNT_RES = 5'h0_3;
   localparam logic [4:0] HWREG_THREAD_LOCAL = 5'h1_d;
   // processor number field of the exception base register
   localparam int PROC_NUM_LSB = 0;
   localparam int PROC_NUM_W = 10;
   // reset values
   localparam logic [31:0] HWREG_ENA_RST = 32'h0000_0000;
   localparam logic [31:0] CNT_RST = 32'h0000_0000;
   // count advances once every this many pipeline cycles
   localparam logic [31:0] CNT_RES_VAL = 32'h0000_0002;
   // cycles the barrier waits for outstanding side effects
   localparam logic [3:0] EXEC_DRAIN_CYC = 4'h4;
   localparam logic [3:0] FULL_DRAIN_CYC = 4'h8;
   // line sizes in bytes, the view returns the smaller
   localparam logic [31:0] ICACHE_LINE = 32'h0000_0020;
   localparam logic [31:0] DCACHE_LINE = 32'h0000_0020;
   // axi-lite register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_HWREG_ENA = 8'h04;
   localparam logic [7:0] A_THREAD_LOCAL = 8'h08;
   localparam logic [7:0] A_EXC_BASE = 8'h0c;
   localparam logic [7:0] A_STATUS = 8'h10;
   localparam logic [7:0] A_COUNT = 8'h14;
   localparam logic [1:0] RESP_OK = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ===== uix_bitops.sv
// combinational bitfield, rotate, extend and swap unit
`timescale 1ns/100ps
`default_nettype none
module uix_bitops (
   input wire uix_pkg::uix_op_t op,
   input wire logic [31:0] rs_val,
   input wire logic [31:0] rt_val,
   input wire logic [4:0] pos,
   input wire logic [4:0] size_m1,
   output logic [31:0] res
);
   import uix_pkg::*;
   logic [4:0] amt;
   logic [31:0] fmask;
   logic [63:0] dbl;
   always_comb begin
      amt = (op == UIX_ROT_REG) ? rs_val[4:0] : pos;
      dbl = {rt_val, rt_val} >> amt;
      fmask = (size_m1 == 5'h1f) ? 32'hffff_ffff :
              ((32'h0000_0001 << (size_m1 + 5'h01)) - 32'h0000_0001);
      res = 32'h0000_0000;
      unique case (op)
         UIX_EXTRACT: res = (rs_val >> pos) & fmask;
         UIX_INSERT: res = (rt_val & ~(fmask << pos)) |
                           ((rs_val & fmask) << pos);
         UIX_ROT_IMM, UIX_ROT_REG: res = dbl[31:0];
         UIX_SIGN_BYTE: res = {{24{rt_val[7]}}, rt_val[7:0]};
         UIX_SIGN_HALF: res = {{16{rt_val[15]}}, rt_val[15:0]};
         UIX_SWAP_HALF_BYTES: res = {rt_val[23:16], rt_val[31:24],
                                     rt_val[7:0], rt_val[15:8]};
         default: res = 32'h0000_0000;
      endcase
   end
endmodule
`default_nettype wire

// ===== uix_upper_mem.sv
// upper-half storage of 64-bit fpu and cop2 registers, registered read
`timescale 1ns/100ps
`default_nettype none
module uix_upper_mem (
   input wire logic clk,
   input wire logic we,
   input wire logic [5:0] waddr,
   input wire logic [31:0] wdata,
   input wire logic [5:0] raddr,
   output logic [31:0] rdata
);
   logic [31:0] mem [0:63];
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule
`default_nettype wire

// ===== uix_core.sv
// user instruction extension unit with hardware register reads
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module uix_core (
   input wire logic CLK,
   input wire logic RSTN,
   // instruction issue port
   input wire logic ISSUE_VALID,
   input wire uix_pkg::uix_op_t ISSUE_OP,
   input wire logic ISSUE_USER,
   input wire logic [31:0] RS_VAL,
   input wire logic [31:0] RT_VAL,
   input wire logic [4:0] POS,
   input wire logic [4:0] SIZE_M1,
   input wire logic [4:0] HWREG_SEL,
   input wire logic [4:0] FREG_SEL,
   input wire logic [31:0] EFF_ADDR,
   input wire logic FETCH_IDLE,
   input wire logic CACHE_DONE,
   output logic ISSUE_READY,
   output logic RES_VALID,
   output logic [31:0] RES_DATA,
   output logic RES_EXC_RI,
   // cache and fpu memory requests
   output logic CACHE_WB_REQ,
   output logic CACHE_INV_REQ,
   output logic [31:0] CACHE_ADDR,
   output logic FPU_MEM_REQ,
   output logic FPU_MEM_WR,
   output logic [31:0] FPU_MEM_ADDR,
   output logic FLUSH_FETCH,
   // axi4-lite slave
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY
);
   import uix_pkg::*;

   typedef enum logic [1:0] {ST_RUN, ST_DRAIN, ST_SYNC, ST_UPPER} uix_st_t;

   typedef struct packed {
      uix_st_t st;
      logic [3:0] drain;
      logic full_bar;
      logic issue_ready;
      logic res_valid;
      logic [31:0] res_data;
      logic res_exc_ri;
      logic wb_req;
      logic inv_req;
      logic [31:0] cache_addr;
      logic fmem_req;
      logic fmem_wr;
      logic [31:0] fmem_addr;
      logic flush_fetch;
      logic [31:0] hwreg_ena;
      logic [31:0] thread_local;
      logic [31:0] exc_base;
      logic [31:0] count;
      logic div;
      logic cnt_run;
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } uix_state_t;

   uix_state_t s_r, s_nxt;
   logic [31:0] bit_res;
   logic [31:0] upper_rd;
   logic upper_we;
   logic [5:0] upper_addr;
   logic [31:0] sync_step;
   logic issue_go;
   logic hw_impl;
   logic hw_allowed;
   logic [31:0] hw_val;
   logic [31:0] wmask;

   uix_bitops u_bitops (
      .op(ISSUE_OP),
      .rs_val(RS_VAL),
      .rt_val(RT_VAL),
      .pos(POS),
      .size_m1(SIZE_M1),
      .res(bit_res)
   );

   // cop2 upper halves sit above the fpu ones
   assign upper_addr = {(ISSUE_OP == UIX_MOVE_TO_COP2_UPPER ||
                         ISSUE_OP == UIX_MOVE_FROM_COP2_UPPER), FREG_SEL};
   assign upper_we = issue_go && (ISSUE_OP == UIX_MOVE_TO_FPU_UPPER ||
                                  ISSUE_OP == UIX_MOVE_TO_COP2_UPPER);

   uix_upper_mem u_upper (
      .clk(CLK),
      .we(upper_we),
      .waddr(upper_addr),
      .wdata(RT_VAL),
      .raddr(upper_addr),
      .rdata(upper_rd)
   );

   assign issue_go = ISSUE_VALID && s_r.issue_ready;
   assign sync_step = (ICACHE_LINE < DCACHE_LINE) ? ICACHE_LINE
                                                  : DCACHE_LINE;
   assign wmask = {{8{s_r.w_strb[3]}}, {8{s_r.w_strb[2]}},
                   {8{s_r.w_strb[1]}}, {8{s_r.w_strb[0]}}};

   always_comb begin
      hw_impl = 1'b1;
      hw_val = 32'h0000_0000;
      unique case (HWREG_SEL)
         HWREG_PROC_NUM: hw_val = 32'(s_r.exc_base[PROC_NUM_LSB +:
                                                  PROC_NUM_W]);
         HWREG_SYNC_STEP: hw_val = sync_step;
         HWREG_CYCLE_VIEW: hw_val = s_r.count;
         HWREG_CNT_RES: hw_val = CNT_RES_VAL;
         HWREG_THREAD_LOCAL: hw_val = s_r.thread_local;
         default: hw_impl = 1'b0;
      endcase
      // privileged reads ignore the mask
      hw_allowed = hw_impl &&
                   (!ISSUE_USER || s_r.hwreg_ena[HWREG_SEL]);
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.res_valid = 1'b0;
      s_nxt.res_exc_ri = 1'b0;
      s_nxt.fmem_req = 1'b0;
      s_nxt.flush_fetch = 1'b0;
      // counter advances once every CNT_RES_VAL cycles
      if (s_r.cnt_run) begin
         s_nxt.div = ~s_r.div;
         if (s_r.div) begin
            s_nxt.count = s_r.count + 32'h0000_0001;
         end
      end
      unique case (s_r.st)
         ST_RUN: begin
            if (issue_go) begin
               s_nxt.res_valid = 1'b1;
               s_nxt.res_data = 32'h0000_0000;
               unique case (ISSUE_OP)
                  UIX_EXEC_BARRIER: begin
                     s_nxt.st = ST_DRAIN;
                     s_nxt.drain = EXEC_DRAIN_CYC;
                     s_nxt.full_bar = 1'b0;
                     s_nxt.issue_ready = 1'b0;
                     s_nxt.res_valid = 1'b0;
                  end
                  UIX_REG_JUMP_HB, UIX_LINK_JUMP_HB, UIX_ERET: begin
                     s_nxt.st = ST_DRAIN;
                     s_nxt.drain = FULL_DRAIN_CYC;
                     s_nxt.full_bar = 1'b1;
                     s_nxt.issue_ready = 1'b0;
                     s_nxt.res_valid = 1'b0;
                     s_nxt.flush_fetch = 1'b1;
                  end
                  UIX_CACHE_SYNC: begin
                     s_nxt.st = ST_SYNC;
                     s_nxt.wb_req = 1'b1;
                     s_nxt.inv_req = 1'b1;
                     s_nxt.cache_addr = EFF_ADDR & ~(sync_step - 32'h1);
                     s_nxt.issue_ready = 1'b0;
                     s_nxt.res_valid = 1'b0;
                  end
                  UIX_MOVE_FROM_FPU_UPPER, UIX_MOVE_FROM_COP2_UPPER: begin
                     s_nxt.st = ST_UPPER;
                     s_nxt.issue_ready = 1'b0;
                     s_nxt.res_valid = 1'b0;
                  end
                  UIX_HWREG_READ: begin
                     if (hw_allowed) begin
                        s_nxt.res_data = hw_val;
                     end else begin
                        s_nxt.res_exc_ri = 1'b1;
                     end
                  end
                  UIX_FPU_LOAD64, UIX_FPU_STORE64: begin
                     s_nxt.fmem_req = 1'b1;
                     s_nxt.fmem_wr = (ISSUE_OP == UIX_FPU_STORE64);
                     s_nxt.fmem_addr = {EFF_ADDR[31:3], 3'b000};
                  end
                  default: s_nxt.res_data = bit_res;
               endcase
            end
         end
         ST_DRAIN: begin
            if (s_r.drain != 4'h0) begin
               s_nxt.drain = s_r.drain - 4'h1;
            end else if (!s_r.full_bar || FETCH_IDLE) begin
               s_nxt.st = ST_RUN;
               s_nxt.issue_ready = 1'b1;
               s_nxt.res_valid = 1'b1;
               s_nxt.res_data = 32'h0000_0000;
            end
         end
         ST_SYNC: begin
            if (CACHE_DONE) begin
               s_nxt.st = ST_RUN;
               s_nxt.wb_req = 1'b0;
               s_nxt.inv_req = 1'b0;
               s_nxt.issue_ready = 1'b1;
               s_nxt.res_valid = 1'b1;
               s_nxt.res_data = 32'h0000_0000;
            end
         end
         ST_UPPER: begin
            s_nxt.st = ST_RUN;
            s_nxt.issue_ready = 1'b1;
            s_nxt.res_valid = 1'b1;
            s_nxt.res_data = upper_rd;
         end
      endcase
      // axi4-lite write channel
      if (AWVALID && s_r.awready) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.aw_addr = AWADDR;
         s_nxt.awready = 1'b0;
      end
      if (WVALID && s_r.wready) begin
         s_nxt.w_got = 1'b1;
         s_nxt.w_data = WDATA;
         s_nxt.w_strb = WSTRB;
         s_nxt.wready = 1'b0;
      end
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = RESP_OK;
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         unique case (s_r.aw_addr)
            A_CTRL: s_nxt.cnt_run = (s_r.w_data[0] & s_r.w_strb[0]) |
                                    (s_r.cnt_run & ~s_r.w_strb[0]);
            A_HWREG_ENA: s_nxt.hwreg_ena = (s_r.hwreg_ena & ~wmask) |
                                           (s_r.w_data & wmask);
            A_THREAD_LOCAL: s_nxt.thread_local = (s_r.thread_local & ~wmask) |
                                                 (s_r.w_data & wmask);
            A_EXC_BASE: s_nxt.exc_base = (s_r.exc_base & ~wmask) |
                                         (s_r.w_data & wmask);
            A_COUNT: s_nxt.count = (s_r.count & ~wmask) |
                                   (s_r.w_data & wmask);
            A_STATUS: s_nxt.bresp = RESP_OK;
            default: s_nxt.bresp = RESP_SLVERR;
         endcase
      end
      if (s_r.bvalid && BREADY) begin
         s_nxt.bvalid = 1'b0;
         s_nxt.awready = 1'b1;
         s_nxt.wready = 1'b1;
      end
      // axi4-lite read channel
      if (ARVALID && s_r.arready) begin
         s_nxt.arready = 1'b0;
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = RESP_OK;
         unique case (ARADDR)
            A_CTRL: s_nxt.rdata = {31'h0, s_r.cnt_run};
            A_HWREG_ENA: s_nxt.rdata = s_r.hwreg_ena;
            A_THREAD_LOCAL: s_nxt.rdata = s_r.thread_local;
            A_EXC_BASE: s_nxt.rdata = s_r.exc_base;
            A_STATUS: s_nxt.rdata = {29'h0, s_r.st == ST_SYNC,
                                     s_r.st == ST_DRAIN, s_r.issue_ready};
            A_COUNT: s_nxt.rdata = s_r.count;
            default: begin
               s_nxt.rdata = 32'h0000_0000;
               s_nxt.rresp = RESP_SLVERR;
            end
         endcase
      end
      if (s_r.rvalid && RREADY) begin
         s_nxt.rvalid = 1'b0;
         s_nxt.arready = 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         s_r <= '0;
         s_r.st <= ST_RUN;
         s_r.issue_ready <= 1'b1;
         s_r.hwreg_ena <= HWREG_ENA_RST;
         s_r.count <= CNT_RST;
         s_r.cnt_run <= 1'b1;
         s_r.awready <= 1'b1;
         s_r.wready <= 1'b1;
         s_r.arready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign ISSUE_READY = s_r.issue_ready;
   assign RES_VALID = s_r.res_valid;
   assign RES_DATA = s_r.res_data;
   assign RES_EXC_RI = s_r.res_exc_ri;
   assign CACHE_WB_REQ = s_r.wb_req;
   assign CACHE_INV_REQ = s_r.inv_req;
   assign CACHE_ADDR = s_r.cache_addr;
   assign FPU_MEM_REQ = s_r.fmem_req;
   assign FPU_MEM_WR = s_r.fmem_wr;
   assign FPU_MEM_ADDR = s_r.fmem_addr;
   assign FLUSH_FETCH = s_r.flush_fetch;
   assign AWREADY = s_r.awready;
   assign WREADY = s_r.wready;
   assign BVALID = s_r.bvalid;
   assign BRESP = s_r.bresp;
   assign ARREADY = s_r.arready;
   assign RVALID = s_r.rvalid;
   assign RDATA = s_r.rdata;
   assign RRESP = s_r.rresp;

   // checks
   property p_ena_reset;
      @(posedge CLK) $rose(RSTN) |-> s_r.hwreg_ena == 32'h0000_0000;
   endproperty
   a_ena_reset: assert property (p_ena_reset) else $error("mask not clear");

   property p_exec_bar;
      @(posedge CLK) disable iff (!RSTN)
      issue_go && ISSUE_OP == UIX_EXEC_BARRIER |=> !ISSUE_READY [*5];
   endproperty
   a_exec_bar: assert property (p_exec_bar) else $error("barrier short");

   property p_full_bar;
      @(posedge CLK) disable iff (!RSTN)
      issue_go && (ISSUE_OP == UIX_ERET || ISSUE_OP == UIX_REG_JUMP_HB ||
                   ISSUE_OP == UIX_LINK_JUMP_HB) |=> FLUSH_FETCH ##0
      !ISSUE_READY [*8];
   endproperty
   a_full_bar: assert property (p_full_bar) else $error("full barrier short");

   property p_user_deny;
      @(posedge CLK) disable iff (!RSTN)
      issue_go && ISSUE_OP == UIX_HWREG_READ && ISSUE_USER &&
      !s_r.hwreg_ena[HWREG_SEL] |=> RES_EXC_RI && RES_VALID;
   endproperty
   a_user_deny: assert property (p_user_deny) else $error("user read allowed");

   property p_priv_read;
      @(posedge CLK) disable iff (!RSTN)
      issue_go && ISSUE_OP == UIX_HWREG_READ && !ISSUE_USER &&
      HWREG_SEL == HWREG_CNT_RES |=> !RES_EXC_RI && RES_DATA == CNT_RES_VAL;
   endproperty
   a_priv_read: assert property (p_priv_read) else $error("priv read bad");

   property p_swap;
      @(posedge CLK) disable iff (!RSTN)
      issue_go && ISSUE_OP == UIX_SWAP_HALF_BYTES |=>
      RES_DATA == {$past(RT_VAL[23:16]), $past(RT_VAL[31:24]),
                   $past(RT_VAL[7:0]), $past(RT_VAL[15:8])};
   endproperty
   a_swap: assert property (p_swap) else $error("swap wrong");

   property p_sync;
      @(posedge CLK) disable iff (!RSTN)
      issue_go && ISSUE_OP == UIX_CACHE_SYNC |=> CACHE_WB_REQ && CACHE_INV_REQ
      && !ISSUE_READY;
   endproperty
   a_sync: assert property (p_sync) else $error("sync not issued");

   property p_proc_num;
      @(posedge CLK) disable iff (!RSTN)
      issue_go && ISSUE_OP == UIX_HWREG_READ && !ISSUE_USER &&
      HWREG_SEL == HWREG_PROC_NUM |=>
      RES_DATA == 32'($past(s_r.exc_base[9:0]));
   endproperty
   a_proc_num: assert property (p_proc_num) else $error("cpu num wrong");
endmodule
`default_nettype wire

// ===== uix_core_test.sv
// self-checking bench of the user instruction extension unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
   cmp_count++; \
   if ((g) !== (e)) begin \
      n_errors++; \
      $display("mismatch t=%0t got %h exp %h", $time, g, e); \
   end \
end
module uix_core_test;
   import uix_pkg::*;
   localparam logic [31:0] MIN_LINE =
      (ICACHE_LINE < DCACHE_LINE) ? ICACHE_LINE : DCACHE_LINE;
   logic clk, rstn, iv, iu, fetch_idle, cache_done, ir, rv, rx;
   uix_op_t iop;
   logic [31:0] rs_v, rt_v, ea, rd, ca, fa;
   logic [4:0] pos, sz, sel;
   logic cwb, cinv, fq, fw, ff;
   logic [7:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   int n_errors = 0;
   int cmp_count = 0;
   int lat, idle_hold, cyc;
   logic [31:0] res_d, axi_d, line_a, fpu_a;
   logic res_x, line_s, fpu_s, fpu_w, flush_s;
   logic [1:0] axi_r;
   uix_core uix_core_i (.CLK(clk), .RSTN(rstn), .ISSUE_VALID(iv),
      .ISSUE_OP(iop), .ISSUE_USER(iu), .RS_VAL(rs_v), .RT_VAL(rt_v),
      .POS(pos), .SIZE_M1(sz), .HWREG_SEL(sel), .FREG_SEL(sel),
      .EFF_ADDR(ea), .FETCH_IDLE(fetch_idle), .CACHE_DONE(cache_done),
      .ISSUE_READY(ir), .RES_VALID(rv), .RES_DATA(rd), .RES_EXC_RI(rx),
      .CACHE_WB_REQ(cwb), .CACHE_INV_REQ(cinv), .CACHE_ADDR(ca),
      .FPU_MEM_REQ(fq), .FPU_MEM_WR(fw), .FPU_MEM_ADDR(fa),
      .FLUSH_FETCH(ff), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
      .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
      .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
      .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic test_done();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // far side: cache answers a cycle after the request, fetch drains late
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         test_done();
      end
      cache_done <= cwb;
      if (idle_hold > 0) idle_hold <= idle_hold - 1;
      fetch_idle <= (idle_hold <= 1);
      if (cwb && cinv) begin
         line_s <= 1'b1;
         line_a <= ca;
      end
      if (fq) begin
         fpu_s <= 1'b1;
         fpu_w <= fw;
         fpu_a <= fa;
      end
      if (ff) flush_s <= 1'b1;
   end
   task automatic issue(input uix_op_t op, input logic u,
      input logic [31:0] a, input logic [31:0] b, input logic [4:0] p,
      input logic [4:0] s, input logic [4:0] r);
      @(posedge clk);
      iv <= 1'b1;
      iop <= op;
      iu <= u;
      rs_v <= a;
      rt_v <= b;
      ea <= a;
      pos <= p;
      sz <= s;
      sel <= r;
      @(negedge clk);
      while (!ir) @(negedge clk);
      @(posedge clk);
      iv <= 1'b0;
      lat = 0;
      do begin
         @(negedge clk);
         lat++;
      end while (!rv && lat < 300);
      res_d = rd;
      res_x = rx;
   endtask
   task automatic hw(input logic u, input logic [4:0] r);
      issue(UIX_HWREG_READ, u, 32'h0, 32'h0, 5'h0, 5'h0, r);
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic ha, hd, hb;
      int n;
      hb = 1'b0;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!hb && n < 100) begin
         @(negedge clk);
         ha = awvalid && awready;
         hd = wvalid && wready;
         hb = bvalid;
         axi_r = bresp;
         @(posedge clk);
         if (ha) awvalid <= 1'b0;
         if (hd) wvalid <= 1'b0;
         if (hb) bready <= 1'b0;
         n++;
      end
   endtask
   task automatic axi_rd(input logic [7:0] a);
      logic ha, hb;
      int n;
      hb = 1'b0;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!hb && n < 100) begin
         @(negedge clk);
         ha = arvalid && arready;
         hb = rvalid;
         axi_r = rresp;
         axi_d = rdata;
         @(posedge clk);
         if (ha) arvalid <= 1'b0;
         if (hb) rready <= 1'b0;
         n++;
      end
   endtask
   task automatic t_mask();
      axi_rd(A_HWREG_ENA);
      `CHK(axi_d, HWREG_ENA_RST)
      hw(1'b1, HWREG_SYNC_STEP);
      `CHK(res_x, 1'b1)
      axi_wr(A_EXC_BASE, 32'hffff_f3a5);
      hw(1'b0, HWREG_PROC_NUM);
      `CHK(res_x, 1'b0)
      `CHK(res_d, 32'hffff_f3a5 >> PROC_NUM_LSB & 32'h0000_03ff)
      axi_wr(A_HWREG_ENA, 32'h0000_0002);
      hw(1'b1, HWREG_SYNC_STEP);
      `CHK(res_x, 1'b0)
      `CHK(res_d, MIN_LINE)
      hw(1'b1, HWREG_CNT_RES);
      `CHK(res_x, 1'b1)
      axi_wr(A_HWREG_ENA, 32'h2000_002f);
      axi_wr(A_THREAD_LOCAL, 32'h5a5a_0001);
      hw(1'b1, HWREG_CNT_RES);
      `CHK(res_d, CNT_RES_VAL)
      hw(1'b1, HWREG_THREAD_LOCAL);
      `CHK(res_d, 32'h5a5a_0001)
      hw(1'b1, HWREG_PROC_NUM);
      `CHK(res_x, 1'b0)
      hw(1'b1, 5'h0_5);
      `CHK(res_x, 1'b1)
      axi_wr(A_CTRL, 32'h0000_0000);
      axi_wr(A_COUNT, 32'h1234_5678);
      hw(1'b1, HWREG_CYCLE_VIEW);
      `CHK(res_d, 32'h1234_5678)
      axi_wr(A_CTRL, 32'h0000_0001);
      axi_wr(8'h40, 32'h0000_0001);
      `CHK(axi_r, RESP_SLVERR)
      axi_rd(8'h40);
      `CHK(axi_r, RESP_SLVERR)
      axi_rd(A_STATUS);
      `CHK({axi_r, axi_d}, {RESP_OK, 32'h0000_0001})
   endtask
   task automatic alu(input uix_op_t op, input logic [31:0] a,
      input logic [31:0] b, input logic [4:0] p, input logic [4:0] s,
      input logic [31:0] e);
      issue(op, 1'b1, a, b, p, s, 5'h0);
      `CHK(res_d, e)
   endtask
   task automatic t_alu();
      alu(UIX_EXTRACT, 32'hdead_beef, 0, 8, 7, 32'h0000_00be);
      alu(UIX_INSERT, 32'h0000_abcd, 32'h1111_1111, 4, 7,
         32'h1111_1cd1);
      alu(UIX_INSERT, 32'h0000_abcd, 32'h1111_1111, 0, 31,
         32'h0000_abcd);
      alu(UIX_ROT_IMM, 32'h8765_4321, 32'h8765_4321, 4,
         0, 32'h1876_5432);
      alu(UIX_ROT_REG, 32'h10, 32'h8765_4321, 0, 0, 32'h4321_8765);
      alu(UIX_SIGN_BYTE, 32'h80, 32'h80, 0, 0, 32'hffff_ff80);
      alu(UIX_SIGN_HALF, 32'h1234_7fff, 32'h1234_7fff, 0, 0,
         32'h0000_7fff);
      alu(UIX_SWAP_HALF_BYTES, 32'h1122_3344, 32'h1122_3344, 0, 0,
         32'h2211_4433);
   endtask
   task automatic t_misc();
      issue(UIX_EXEC_BARRIER, 1'b1, 0, 0, 0, 0, 0);
      `CHK(lat, 6)
      flush_s = 1'b0;
      idle_hold = 20;
      issue(UIX_REG_JUMP_HB, 1'b1, 0, 0, 0, 0, 0);
      `CHK(lat > 18 && flush_s, 1'b1)
      issue(UIX_LINK_JUMP_HB, 1'b1, 0, 0, 0, 0, 0);
      `CHK(lat >= 10, 1'b1)
      idle_hold = 14;
      issue(UIX_ERET, 1'b0, 0, 0, 0, 0, 0);
      `CHK(lat > 12, 1'b1)
      line_s = 1'b0;
      issue(UIX_CACHE_SYNC, 1'b1, 32'h0000_1234, 0, 0, 0, 0);
      `CHK({res_x, line_s}, 2'b01)
      `CHK(line_a, 32'h0000_1234 & ~(MIN_LINE - 1))
      issue(UIX_MOVE_TO_FPU_UPPER, 1'b1, 32'h0bad_f00d, 32'h0bad_f00d,
         0, 0, 5);
      issue(UIX_MOVE_TO_COP2_UPPER, 1'b1, 32'hc0de_0002, 32'hc0de_0002,
         0, 0, 5);
      issue(UIX_MOVE_FROM_FPU_UPPER, 1'b1, 0, 0, 0, 0, 5);
      `CHK({lat == 2, res_d}, {1'b1, 32'h0bad_f00d})
      issue(UIX_MOVE_FROM_COP2_UPPER, 1'b1, 0, 0, 0, 0, 5);
      `CHK(res_d, 32'hc0de_0002)
      fpu_s = 1'b0;
      issue(UIX_FPU_LOAD64, 1'b1, 32'h1000_000c, 0, 0, 0, 2);
      // the request pulse is captured at the edge after the result shows
      @(negedge clk);
      `CHK({fpu_s, fpu_w, fpu_a}, {2'b10, 32'h1000_0008})
      issue(UIX_FPU_STORE64, 1'b1, 32'h2000_0014, 0, 0, 0, 2);
      @(negedge clk);
      `CHK({fpu_w, fpu_a}, {1'b1, 32'h2000_0010})
   endtask
   initial begin
      {rstn, iv, iu, cache_done, awvalid, wvalid, bready} = '0;
      {arvalid, rready, rs_v, rt_v, ea, pos, sz, sel} = '0;
      {awaddr, araddr, wdata, cyc, idle_hold} = '0;
      {line_s, fpu_s, flush_s, line_a, fpu_a, fpu_w} = '0;
      iop = UIX_NOP;
      wstrb = 4'hf;
      fetch_idle = 1'b1;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      t_mask();
      t_alu();
      t_misc();
      test_done();
   end
endmodule
`default_nettype wire
